// ---- rtl/adc_output_port.sv ----
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// [R01] Parallel mode: all sixteen pins driven only while chip select and read both low, registered one cycle later.
// [R02] Parallel mode: bit 14 copies result bit 13.
// [R03] Parallel mode: bit 15 copies result bit 13.
// [R04] Select high, byte select low: serial interface.
// [R05] Select and byte select high: byte mode, bit 14 pin is byte order.
// [R06] Byte mode, order high: upper byte first, lower second.
// [R07] Byte mode, order low: lower byte first, upper second.
// [R08] Reference select high enables the internal reference.
// [R09] Reference select low: board supplies external reference.
// [R10] Byte mode: result in two reads on low eight lines, bit 7 MSB.
// [R11] Host keeps mode inputs stable during a read sequence.
module adc_output_port
    import port_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [BUS_BITS-1:0] bus_in,
    output logic [BUS_BITS-1:0] bus_out,
    output logic [BUS_BITS-1:0] bus_oe,
    output logic internal_ref_enable
);

    typedef struct packed {
        logic [3:0] ctrl;
        logic [RESULT_BITS-1:0] result;
        logic rd_active;
        logic second_read;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        bus_drive_s drive;
        logic ref_en;
    } state_s;

    state_s cur_q;
    state_s nxt_d;
    bus_drive_s drive_w;
    port_mode_e mode_w;
    logic upper_first_w;
    logic rd_now;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic port_mode_e decode_mode(input logic ifsel, input logic bytesel);
        if (!ifsel)
            decode_mode = MODE_PARALLEL;
        else if (bytesel)
            decode_mode = MODE_BYTE; // [R05]
        else
            decode_mode = MODE_SERIAL; // [R04]
    endfunction : decode_mode

    // [R11] Mode inputs are sampled live; the host keeps them steady across reads.
    assign mode_w = decode_mode(cur_q.ctrl[CTRL_IFSEL_BIT], cur_q.ctrl[CTRL_BYTESEL_BIT]);
    assign upper_first_w = (mode_w == MODE_BYTE) ? bus_in[BUS_BITS-2]
                                                 : cur_q.ctrl[CTRL_ORDER_BIT]; // [R05]
    assign rd_now = !cs_n && !rd_n;

    bus_drive u_drive (
        .result(cur_q.result),
        .mode(mode_w),
        .rd_active(rd_now),
        .second_read(cur_q.second_read),
        .upper_byte_first(upper_first_w),
        .drive(drive_w)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_d = cur_q;
        nxt_d.drive = drive_w;
        nxt_d.rd_active = rd_now;
        nxt_d.pready = 1'b0;
        nxt_d.pslverr = 1'b0;
        nxt_d.ref_en = cur_q.ctrl[CTRL_REFSEL_BIT]; // [R08] [R09]
        if (cs_n)
            nxt_d.second_read = 1'b0;
        else if (cur_q.rd_active && !rd_now && mode_w == MODE_BYTE)
            nxt_d.second_read = !cur_q.second_read; // [R10]
        if (psel && !penable)
        begin
            nxt_d.pready = 1'b1;
            nxt_d.prdata = '0;
            unique case (paddr)
                CTRL_ADDR:
                begin
                    if (pwrite)
                        nxt_d.ctrl = pwdata[3:0];
                    nxt_d.prdata[3:0] = pwrite ? pwdata[3:0] : cur_q.ctrl;
                end
                RESULT_ADDR:
                begin
                    if (pwrite)
                        nxt_d.result = pwdata[RESULT_BITS-1:0];
                    nxt_d.prdata[RESULT_BITS-1:0] = pwrite ? pwdata[RESULT_BITS-1:0]
                                                           : cur_q.result;
                end
                STATUS_ADDR:
                    nxt_d.prdata = {28'h0000000, cur_q.second_read, cur_q.rd_active,
                                    mode_w};
                default:
                    nxt_d.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_q <= '0;
            cur_q.ctrl <= CTRL_RESET;
            cur_q.ref_en <= 1'b1;
        end
        else
            cur_q <= nxt_d;
    end

    assign prdata = cur_q.prdata;
    assign pready = cur_q.pready;
    assign pslverr = cur_q.pslverr;
    assign bus_out = cur_q.drive.dout;
    assign bus_oe = cur_q.drive.doe;
    assign internal_ref_enable = cur_q.ref_en;

endmodule : adc_output_port

// ---- rtl/bus_drive.sv ----
`timescale 1ns/1ps
module bus_drive
    import port_pkg::*;
(
    input wire logic [RESULT_BITS-1:0] result,
    input wire port_mode_e mode,
    input wire logic rd_active,
    input wire logic second_read,
    input wire logic upper_byte_first,
    output bus_drive_s drive
);

    // ------------------------------------------------------------
    // Pin driver selection
    // ------------------------------------------------------------
    logic [BUS_BITS-1:0] wide;
    logic [BYTE_BITS-1:0] hi_byte;
    logic [BYTE_BITS-1:0] lo_byte;
    logic take_hi;

    always_comb
    begin
        wide = {{(BUS_BITS-RESULT_BITS){result[RESULT_BITS-1]}}, result}; // [R02] [R03]
        hi_byte = wide[2*BYTE_BITS-1:BYTE_BITS];
        lo_byte = wide[BYTE_BITS-1:0];
        take_hi = upper_byte_first ^ second_read; // [R06] [R07]
        drive.dout = '0;
        drive.doe = '0;
        unique case (mode)
            MODE_PARALLEL:
            begin
                drive.dout = wide;
                drive.doe = {BUS_BITS{rd_active}}; // [R01]
            end
            MODE_BYTE:
            begin
                drive.dout[BYTE_BITS-1:0] = take_hi ? hi_byte : lo_byte; // [R10]
                drive.doe[BYTE_BITS-1:0] = {BYTE_BITS{rd_active}};
            end
            MODE_SERIAL:
            begin
                drive.dout = '0; // [R04]
                drive.doe = '0;
            end
        endcase
    end

endmodule : bus_drive

// ---- rtl/port_pkg.sv ----
package port_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] RESULT_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;

    localparam int CTRL_IFSEL_BIT = 0;
    localparam int CTRL_BYTESEL_BIT = 1;
    localparam int CTRL_ORDER_BIT = 2;
    localparam int CTRL_REFSEL_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;

    localparam int RESULT_BITS = 14;
    localparam int BUS_BITS = 16;
    localparam int BYTE_BITS = 8;

    typedef enum logic [1:0] {
        MODE_PARALLEL,
        MODE_SERIAL,
        MODE_BYTE
    } port_mode_e;

    typedef struct packed {
        logic [BUS_BITS-1:0] dout;
        logic [BUS_BITS-1:0] doe;
    } bus_drive_s;

endpackage : port_pkg

// ---- test/host_model.sv ----
`timescale 1ns/1ps
module host_model
    import port_pkg::*;
(
    input wire logic pclk,
    input wire logic order,
    input wire logic [BUS_BITS-1:0] bus_out,
    input wire logic [BUS_BITS-1:0] bus_oe,
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic [BUS_BITS-1:0] bus_in
);
    logic [BUS_BITS-1:0] pat = 16'h5A5A;
    // Released lines float, so the port sees a level that moves each cycle, except bit 14, which carries order.
    always @(posedge pclk) pat <= ~pat;
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & {pat[15], order, pat[13:0]});
    task automatic rd(input logic keep, output logic [31:0] d);
        @(posedge pclk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        d = {bus_oe, bus_out};
        @(posedge pclk);
        rd_n <= 1'b1;
        cs_n <= !keep;
        @(posedge pclk);
    endtask : rd
endmodule : host_model

// ---- test/port_asserts.sv ----
`timescale 1ns/1ps
module port_asserts
    import port_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [BUS_BITS-1:0] bus_out,
    input wire logic [BUS_BITS-1:0] bus_oe,
    input wire logic internal_ref_enable
);
    wire logic wr = psel && penable && pwrite && paddr == CTRL_ADDR;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    property p_rdy; s_setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_off; cs_n || rd_n |=> bus_oe == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("bus driven idle");
    property p_on; $rose(bus_oe[0]) |-> $past(!cs_n && !rd_n); endproperty
    a_on: assert property (p_on) else $error("drive unasked");
    property p_s14; bus_oe[14] |-> bus_out[14] == bus_out[13]; endproperty
    a_s14: assert property (p_s14) else $error("bit 14 sign");
    property p_s15; bus_oe[15] |-> bus_out[15] == bus_out[13]; endproperty
    a_s15: assert property (p_s15) else $error("bit 15 sign");
    property p_lane; bus_oe inside {16'h0000, 16'h00FF, 16'hFFFF}; endproperty
    a_lane: assert property (p_lane) else $error("bad lanes");
    property p_ref; $changed(internal_ref_enable) |-> $past(wr) || $past(wr, 2); endproperty
    a_ref: assert property (p_ref) else $error("ref moved");
endmodule : port_asserts

// ---- test/tb_adc_output_port_mode_select.sv ----
`timescale 1ns/1ps
module tb_adc_output_port_mode_select;
    import port_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic order = 1'b0, pready, pslverr, err, cs_n, rd_n, ref_en;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d, e;
    logic [15:0] bus_in, bus_out, bus_oe, s;
    logic [13:0] r;
    int mismatches = 0, checks = 0, cycles = 0, seed = 89384, m;
    always #10 pclk = ~pclk;
    adc_output_port u_adc_output_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .rd_n(rd_n), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe(bus_oe), .internal_ref_enable(ref_en));
    host_model u_host_model (.pclk(pclk), .order(order), .bus_out(bus_out),
        .bus_oe(bus_oe), .cs_n(cs_n), .rd_n(rd_n), .bus_in(bus_in));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(48'({d[3:0], ref_en}), 48'h11);
        apb(1'b0, 12'h00C, 32'h0);
        chk(48'(err), 48'h1);
        apb(1'b1, CTRL_ADDR, 32'h0);
        @(posedge pclk);
        chk(48'(ref_en), 48'h0);
        for (int i = 0; i < 9; i++)
        begin
            m = i % 3;
            r = 14'($random(seed));
            s = {r[13], r[13], r};
            order <= (i == 5);
            apb(1'b1, CTRL_ADDR, m == 0 ? 32'h0 : m == 1 ? 32'h1 : 32'h3);
            apb(1'b1, RESULT_ADDR, {18'h0, r});
            apb(1'b0, RESULT_ADDR, 32'h0);
            chk(48'(d), 48'(r));
            apb(1'b0, STATUS_ADDR, 32'h0);
            chk(48'(d[1:0]), 48'(m));
            u_host_model.rd(m == 2, d);
            u_host_model.rd(1'b0, e);
            if (m == 0)
                chk(48'(d), {16'h0, 16'hFFFF, s});
            if (m == 1)
                chk(48'({d[31:16], e[31:16]}), 48'h0);
            if (m == 2)
                chk({d[31:16], d[7:0], e[31:16], e[7:0]}, order ?
                    {16'h00FF, s[15:8], 16'h00FF, s[7:0]} :
                    {16'h00FF, s[7:0], 16'h00FF, s[15:8]});
        end
        print_verdict();
    end
endmodule : tb_adc_output_port_mode_select
bind adc_output_port port_asserts u_port_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .rd_n(rd_n), .bus_out(bus_out), .bus_oe(bus_oe),
    .internal_ref_enable(internal_ref_enable));
